// *** hdl/output_power_control.sv ***
// output enable and synth power control core with register access
//
// Behaviour
// - no override: enable pin decides output
// - no override: on bit reads pin level
// - override: on bit takes the place of the pin in deciding output
// - unpowered synth keeps its outputs off
// - first synth follows powerdown pin without override
// - first synth override: power from bit one
// - second synth powered from bit three only
// - enable: static levels for two microseconds first
// - disable: stop toggling, then bias off
// - two-bit field selects cmos, lvds, pecl, hcsl
// - cmos drives true pin, complement floats
// - override bits load from programmed storage
// - programmed override off locks output off
// - formats reset to cmos, rewritable together
// - reference buffer uses same scheme, bits 17:16
// - format fields low byte, crystal fields high
`timescale 1ns/1ps
module output_power_control #(
  parameter int SETTLE_CYCLES = clkctl_pkg::SETTLE_CYCLES,
  parameter int STOP_CYCLES   = clkctl_pkg::STOP_CYCLES
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire logic [3:0]                    output_enable_pin,
  input  wire logic                          reference_buffer_enable_pin,
  input  wire logic                          first_synth_powerdown_pin_n,
  input  wire logic [1:0]                    reference_buffer_format,
  input  wire logic                          otp_load,
  input  wire logic [clkctl_pkg::REG2_W-1:0] otp_output_ctrl,
  input  wire logic [clkctl_pkg::REG4_W-1:0] otp_format,
  input  wire logic [clkctl_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [clkctl_pkg::REG2_W-1:0] reg_wdata,
  output      logic [clkctl_pkg::REG2_W-1:0] reg_rdata,
  output      logic                          first_synth_powered,
  output      logic                          second_synth_powered,
  output      logic [4:0]                    driver_bias_on,
  output      logic [4:0]                    clock_toggle_en,
  output      logic [4:0]                    true_pin_oe,
  output      logic [4:0]                    comp_pin_oe,
  output      logic [7:0]                    driver_format_field,
  output      logic [2:0]                    crystal_amp_gain,
  output      logic [2:0]                    crystal_load_cap,
  output      logic                          crystal_freq_trim
);
  import clkctl_pkg::*;

  if (SETTLE_CYCLES < 1 || STOP_CYCLES < 1) begin : g_bad
    $error("timing counts must be at least one");
  end

  // ==========================================================
  // field decoding
  function automatic int ovr_pos(input int idx);
    return (idx == REF_IDX) ? B_REF_OVR : B_OUT_BASE + 2 * idx;
  endfunction

  function automatic logic pick_enable(input logic ovr, input logic on,
                                       input logic pin);
    return ovr ? on : pin;
  endfunction

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // pin synchronisers
  logic [NUM_DRV:0] pin_meta;
  logic [NUM_DRV:0] pin_sync;
  logic [NUM_DRV:0] pin_raw;

  assign pin_raw = {first_synth_powerdown_pin_n,
                    reference_buffer_enable_pin, output_enable_pin};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  logic pdn_pin_up;
  assign pdn_pin_up = pin_sync[NUM_DRV];

  // ==========================================================
  // registers
  logic [REG2_W-1:0] out_ctrl;
  logic [REG4_W-1:0] fmt_reg;
  logic [NUM_DRV-1:0] otp_lock;

  function automatic logic [REG2_W-1:0] merge_wr(
    input logic [REG2_W-1:0] old_v, input logic [REG2_W-1:0] new_v);
    logic [REG2_W-1:0] res;
    res = new_v & REG2_MASK;
    for (int i = 0; i < NUM_DRV; i++) begin
      if (!new_v[ovr_pos(i)]) res[ovr_pos(i) + 1] = old_v[ovr_pos(i) + 1];
    end
    return res;
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) out_ctrl <= REG2_RESET;
    else if (otp_load) out_ctrl <= otp_output_ctrl & REG2_MASK;
    else if (reg_wr && reg_addr == REG2_ADDR)
      out_ctrl <= merge_wr(out_ctrl, reg_wdata);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) fmt_reg <= REG4_RESET;
    else if (otp_load) fmt_reg <= otp_format & REG4_MASK;
    else if (reg_wr && reg_addr == REG4_ADDR)
      fmt_reg <= reg_wdata[REG4_W-1:0] & REG4_MASK;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) otp_lock <= '0;
    else if (otp_load) begin
      for (int i = 0; i < NUM_DRV; i++) begin
        if (otp_output_ctrl[ovr_pos(i)] && !otp_output_ctrl[ovr_pos(i) + 1])
          otp_lock[i] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // register readback
  logic [REG2_W-1:0] rd_ctrl;

  always_comb begin
    rd_ctrl = out_ctrl;
    for (int i = 0; i < NUM_DRV; i++) begin
      if (!out_ctrl[ovr_pos(i)]) rd_ctrl[ovr_pos(i) + 1] = pin_sync[i];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= '0;
    else if (reg_rd) begin
      if (reg_addr == REG2_ADDR) reg_rdata <= rd_ctrl;
      else if (reg_addr == REG4_ADDR)
        reg_rdata <= {{(REG2_W - REG4_W){1'b0}}, fmt_reg};
      else reg_rdata <= '0;
    end
  end

  // ==========================================================
  // synth power
  logic synth1_on;
  logic synth2_on;

  assign synth1_on = pick_enable(out_ctrl[B_SYN1_OVR], out_ctrl[B_SYN1_ON],
                                 pdn_pin_up);
  assign synth2_on = out_ctrl[B_SYN2_ON];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_synth_powered  <= 1'b0;
      second_synth_powered <= 1'b0;
    end else begin
      first_synth_powered  <= synth1_on;
      second_synth_powered <= synth2_on;
    end
  end

  // ==========================================================
  // format and crystal fields
  // field placement
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      driver_format_field <= '0;
      crystal_amp_gain    <= '0;
      crystal_load_cap    <= '0;
      crystal_freq_trim   <= 1'b0;
    end else begin
      driver_format_field <= fmt_reg[NUM_CLK_OUT*FMT_W-1:0];
      crystal_amp_gain    <= fmt_reg[GAIN_LSB +: XTAL_FIELD_W];
      crystal_load_cap    <= fmt_reg[CAP_LSB +: XTAL_FIELD_W];
      crystal_freq_trim   <= fmt_reg[TRIM_BIT];
    end
  end

  // ==========================================================
  // per output enable and sequencing
  logic [NUM_DRV-1:0] enable_req;

  for (genvar g = 0; g < NUM_DRV; g++) begin : g_drv
    output_seq_if seq_bus ();
    logic synth_ok;

    if (g == REF_IDX) begin : g_ref
      assign synth_ok = 1'b1;
      assign seq_bus.format = format_type'(reference_buffer_format);
    end else begin : g_clk
      assign synth_ok = (g < SYN1_OUTS) ? synth1_on : synth2_on;
      assign seq_bus.format =
        format_type'(fmt_reg[g*FMT_W +: FMT_W]);
    end

    assign enable_req[g] = synth_ok && !otp_lock[g] &&
      pick_enable(out_ctrl[ovr_pos(g)], out_ctrl[ovr_pos(g) + 1],
                  pin_sync[g]);
    assign seq_bus.enable = enable_req[g];

    output_sequencer #(
      .SETTLE_CYCLES (SETTLE_CYCLES),
      .STOP_CYCLES   (STOP_CYCLES)
    ) u_seq (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .bus   (seq_bus.seq)
    );

    assign driver_bias_on[g]  = seq_bus.bias_on;
    assign clock_toggle_en[g] = seq_bus.run;
    assign true_pin_oe[g]     = seq_bus.oe_true;
    assign comp_pin_oe[g]     = seq_bus.oe_comp;
  end

  // ==========================================================
  // checks
  a_synth1_pin: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !out_ctrl[B_SYN1_OVR] && !pdn_pin_up |=> !first_synth_powered)
    else $error("first synth powered with pin low");
  a_synth1_reg: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    out_ctrl[B_SYN1_OVR] |=>
      first_synth_powered == $past(out_ctrl[B_SYN1_ON]))
    else $error("first synth ignores its power bit");
  a_synth2_reg: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ##1 second_synth_powered == $past(out_ctrl[B_SYN2_ON]))
    else $error("second synth ignores its power bit");
  a_synth_gate: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !synth1_on |-> !enable_req[0] && !enable_req[1])
    else $error("output requested with synth down");
  a_synth_off_hold: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !synth1_on && true_pin_oe[1:0] == 2'b00
      |=> true_pin_oe[1:0] == 2'b00)
    else $error("output driven with synth down");
  a_pin_control: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !out_ctrl[B_OUT_BASE] && !otp_lock[0] && synth1_on
      |-> enable_req[0] == pin_sync[0])
    else $error("pin does not steer first output");
  a_override_on: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    out_ctrl[B_OUT_BASE] |-> enable_req[0] ==
      (out_ctrl[B_OUT_BASE + 1] && synth1_on && !otp_lock[0]))
    else $error("override does not follow on bit");
  a_ref_pin: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !out_ctrl[B_REF_OVR] && !otp_lock[REF_IDX]
      |-> enable_req[REF_IDX] == pin_sync[REF_IDX])
    else $error("pin does not steer reference buffer");
  a_ref_override: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    out_ctrl[B_REF_OVR] |-> enable_req[REF_IDX] ==
      (out_ctrl[B_REF_OVR + 1] && !otp_lock[REF_IDX]))
    else $error("override does not steer reference buffer");
  a_readback_pin: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    reg_rd && reg_addr == REG2_ADDR && !out_ctrl[B_REF_OVR]
      |=> reg_rdata[B_REF_OVR + 1] == $past(pin_sync[REF_IDX]))
    else $error("readback does not show pin level");
  a_otp_lock: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    otp_lock[0] |-> !enable_req[0] ##1 otp_lock[0])
    else $error("locked output requested");

endmodule

// *** hdl/clkctl_pkg.sv ***
// constants, types and field layout of the output and synth power control
package clkctl_pkg;

  // ==========================================================
  // register map
  localparam int          ADDR_W      = 4;
  localparam int          REG2_W      = 24;
  localparam int          REG4_W      = 16;
  localparam logic [3:0]  REG2_ADDR   = 4'h2;
  localparam logic [3:0]  REG4_ADDR   = 4'h4;
  localparam logic [23:0] REG2_RESET  = 24'h000000;
  localparam logic [15:0] REG4_RESET  = 16'h0000;
  localparam logic [23:0] REG2_MASK   = 24'h0fffff;
  localparam logic [15:0] REG4_MASK   = 16'hf7ff;

  // ==========================================================
  // control register fields
  localparam int B_SYN1_OVR   = 0;
  localparam int B_SYN1_ON    = 1;
  localparam int B_SYN2_OVR   = 2;
  localparam int B_SYN2_ON    = 3;
  localparam int B_OUT_BASE   = 8;
  localparam int B_REF_OVR    = 16;
  localparam int NUM_CLK_OUT  = 4;
  localparam int NUM_DRV      = 5;
  localparam int REF_IDX      = 4;
  localparam int SYN1_OUTS    = 2;

  // ==========================================================
  // format register fields
  localparam int FMT_W        = 2;
  localparam int GAIN_LSB     = 8;
  localparam int CAP_LSB      = 12;
  localparam int TRIM_BIT     = 15;
  localparam int XTAL_FIELD_W = 3;

  typedef enum logic [1:0] {
    FMT_CMOS  = 2'b00,
    FMT_LVDS  = 2'b01,
    FMT_PECL  = 2'b10,
    FMT_HCSL  = 2'b11
  } format_type;

  typedef enum logic [1:0] {
    SEQ_OFF    = 2'b00,
    SEQ_SETTLE = 2'b01,
    SEQ_RUN    = 2'b10,
    SEQ_STOP   = 2'b11
  } seq_state_type;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int SETTLE_TIME_NS = 2000;
  localparam int STOP_TIME_NS   = 16;
  localparam int SETTLE_CYCLES  =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_CYCLES    =
    (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// *** hdl/output_seq_if.sv ***
// request and driver controls between control core and one sequencer
`timescale 1ns/1ps
interface output_seq_if;
  import clkctl_pkg::*;
  logic       enable;
  format_type format;
  logic       bias_on;
  logic       run;
  logic       oe_true;
  logic       oe_comp;

  modport seq  (input enable, format,
                output bias_on, run, oe_true, oe_comp);
  modport ctrl (output enable, format,
                input bias_on, run, oe_true, oe_comp);
endinterface

// *** hdl/output_sequencer.sv ***
// glitch-free enable and disable sequencing of one output driver
`timescale 1ns/1ps
module output_sequencer #(
  parameter int SETTLE_CYCLES = clkctl_pkg::SETTLE_CYCLES,
  parameter int STOP_CYCLES   = clkctl_pkg::STOP_CYCLES
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  output_seq_if.seq   bus
);
  import clkctl_pkg::*;

  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] SETTLE_LOAD = CW'(SETTLE_CYCLES - 1);
  localparam logic [CW-1:0] STOP_LOAD   = CW'(STOP_CYCLES - 1);
  localparam logic [CW-1:0] ZERO        = '0;

  if (STOP_CYCLES < 1 || SETTLE_CYCLES < STOP_CYCLES) begin : g_bad
    $error("sequencer timing out of range");
  end

  seq_state_type   state;
  seq_state_type   next_state;
  logic [CW-1:0]   count;

  // ==========================================================
  // state transitions
  always_comb begin
    next_state = state;
    unique case (state)
      SEQ_OFF: begin
        if (bus.enable) next_state = SEQ_SETTLE;
      end
      SEQ_SETTLE: begin
        if (!bus.enable) next_state = SEQ_OFF;
        else if (count == ZERO) next_state = SEQ_RUN;
      end
      SEQ_RUN: begin
        if (!bus.enable) next_state = SEQ_STOP;
      end
      SEQ_STOP: begin
        if (count == ZERO) next_state = SEQ_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state <= SEQ_OFF;
    else state <= next_state;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) count <= ZERO;
    else if (state != SEQ_SETTLE && next_state == SEQ_SETTLE)
      count <= SETTLE_LOAD;
    else if (state != SEQ_STOP && next_state == SEQ_STOP)
      count <= STOP_LOAD;
    else if (count != ZERO) count <= count - 1'b1;
  end

  // ==========================================================
  // driver controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.bias_on <= 1'b0;
      bus.run     <= 1'b0;
      bus.oe_true <= 1'b0;
      bus.oe_comp <= 1'b0;
    end else begin
      bus.bias_on <= next_state != SEQ_OFF;
      bus.run     <= next_state == SEQ_RUN;
      bus.oe_true <= next_state != SEQ_OFF;
      bus.oe_comp <= next_state != SEQ_OFF && bus.format != FMT_CMOS;
    end
  end

  a_settle_time: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(bus.run) |-> $past(bus.bias_on, SETTLE_CYCLES))
    else $error("output toggled before settle time");
  a_run_biased: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(bus.run) |-> bus.bias_on && bus.oe_true)
    else $error("driver released before toggling stopped");
  a_comp_cmos: assert property (@(posedge clk) disable iff (!rst_n)
    bus.oe_comp |-> $past(bus.format) != FMT_CMOS)
    else $error("complement driven in cmos format");

endmodule

// *** tb/serial_host_model.sv ***
// host model driving the register strobe port
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic [0:0]                    ref_clk,
  output      logic [clkctl_pkg::ADDR_W-1:0] reg_addr,
  output      logic                          reg_wr,
  output      logic                          reg_rd,
  output      logic [clkctl_pkg::REG2_W-1:0] reg_wdata,
  input  wire logic [clkctl_pkg::REG2_W-1:0] reg_rdata
);
  import clkctl_pkg::*;
  // ==========================================================
  // idle levels
  initial begin
    reg_addr  = 4'hd;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 24'h000000;
  end
  task automatic boot_wait(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule

// *** tb/output_power_control_bench.sv ***
// self-checking bench of output enable and synth power control
`timescale 1ns/1ps
module output_power_control_bench;
  import clkctl_pkg::*;
  localparam int SETTLE = 4;
  localparam int STOP   = 1;
  typedef struct packed {
    logic [23:0] wd;
    logic [3:0]  pins;
    logic        refp;
    logic        pdn;
    logic [23:0] rd;
    logic [1:0]  pll;
    logic [4:0]  drv;
  } row_type;
  localparam row_type ROWS [6] = '{
    '{24'h00000c, 4'hf, 1'b1, 1'b1, 24'h02aa0c, 2'b11, 5'h1f},
    '{24'h00000c, 4'h5, 1'b0, 1'b0, 24'h00220c, 2'b01, 5'h04},
    '{24'h000007, 4'hf, 1'b1, 1'b0, 24'h02aa07, 2'b10, 5'h13},
    '{24'h01070f, 4'h0, 1'b1, 1'b0, 24'h01070f, 2'b11, 5'h01},
    '{24'h03ff0f, 4'h0, 1'b0, 1'b0, 24'h03ff0f, 2'b11, 5'h1f},
    '{24'hf1550f, 4'hf, 1'b1, 1'b1, 24'h01550f, 2'b11, 5'h00}
  };
  logic              ref_clk;
  logic              rstn;
  logic [3:0]        output_enable_pin;
  logic              reference_buffer_enable_pin;
  logic              first_synth_powerdown_pin_n;
  logic [1:0]        reference_buffer_format;
  logic              otp_load;
  logic [REG2_W-1:0] otp_output_ctrl;
  logic [REG4_W-1:0] otp_format;
  logic [ADDR_W-1:0] reg_addr;
  logic              reg_wr;
  logic              reg_rd;
  logic [REG2_W-1:0] reg_wdata;
  logic [REG2_W-1:0] reg_rdata;
  logic              first_synth_powered;
  logic              second_synth_powered;
  logic [4:0]        driver_bias_on;
  logic [4:0]        clock_toggle_en;
  logic [4:0]        true_pin_oe;
  logic [4:0]        comp_pin_oe;
  logic [7:0]        driver_format_field;
  logic [2:0]        crystal_amp_gain;
  logic [2:0]        crystal_load_cap;
  logic              crystal_freq_trim;
  logic [23:0]       rv;
  logic [1:0]        pw;
  int                n;
  int                num_errors;
  int                check_count;

  output_power_control #(.SETTLE_CYCLES(SETTLE), .STOP_CYCLES(STOP)) DUT (
    .ref_clk, .rstn, .output_enable_pin, .reference_buffer_enable_pin,
    .first_synth_powerdown_pin_n, .reference_buffer_format, .otp_load,
    .otp_output_ctrl, .otp_format, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .first_synth_powered, .second_synth_powered,
    .driver_bias_on, .clock_toggle_en, .true_pin_oe, .comp_pin_oe,
    .driver_format_field, .crystal_amp_gain, .crystal_load_cap,
    .crystal_freq_trim
  );
  serial_host_model host (
    .ref_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata
  );

  // ==========================================================
  // compare and report
  task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_cnt(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      num_errors++;
      $display("MISMATCH t=%0t count %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // waits on driver 0: sel picks toggle or bias
  task automatic wait_for(input logic sel, input logic lvl, output int cyc);
    cyc = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cyc++;
    end while ((sel ? clock_toggle_en[0] : driver_bias_on[0]) !== lvl
               && cyc < 40);
    if ((sel ? clock_toggle_en[0] : driver_bias_on[0]) !== lvl) begin
      num_errors++;
      $display("MISMATCH t=%0t wait timed out", $time);
      give_verdict();
    end
  endtask

  // ==========================================================
  // stimulus
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    rstn = 1'b0;
    output_enable_pin = 4'hf;
    reference_buffer_enable_pin = 1'b1;
    first_synth_powerdown_pin_n = 1'b1;
    reference_buffer_format = 2'b00;
    otp_load = 1'b0;
    otp_output_ctrl = 24'h000000;
    otp_format = 16'h0000;
    num_errors = 0;
    check_count = 0;
    repeat (5) @(posedge ref_clk);
    #1;
    check_val(24'({driver_bias_on, first_synth_powered}), 24'h0);
    rstn = 1'b1;
    host.boot_wait(3);
    host.rd(REG2_ADDR, rv);
    check_val(rv, 24'h02aa00);
    host.rd(REG4_ADDR, rv);
    check_val(rv, 24'h000000);
    host.wr(4'h7, 24'hffffff);
    host.rd(4'h7, rv);
    check_val(rv, 24'h000000);
    host.rd(REG2_ADDR, rv);
    check_val(rv, 24'h02aa00);
    repeat (8) @(posedge ref_clk);
    #1;
    check_val(24'(driver_bias_on), 24'h000013);
    check_val(24'(comp_pin_oe), 24'h0);
    $display("test reset done");
    foreach (ROWS[i]) begin
      output_enable_pin = ROWS[i].pins;
      reference_buffer_enable_pin = ROWS[i].refp;
      first_synth_powerdown_pin_n = ROWS[i].pdn;
      host.wr(REG2_ADDR, ROWS[i].wd);
      repeat (16) @(posedge ref_clk);
      #1;
      host.rd(REG2_ADDR, rv);
      pw = {first_synth_powered, second_synth_powered};
      check_val(rv, ROWS[i].rd);
      check_val(24'(pw), 24'(ROWS[i].pll));
      check_val(24'(driver_bias_on), 24'(ROWS[i].drv));
      check_val(24'(clock_toggle_en), 24'(ROWS[i].drv));
      check_val(24'(true_pin_oe), 24'(ROWS[i].drv));
      check_val(24'(comp_pin_oe), 24'h0);
    end
    $display("test table done");
    reference_buffer_format = 2'b01;
    host.wr(REG4_ADDR, 24'h00ffe4);
    host.rd(REG4_ADDR, rv);
    check_val(rv, 24'h00f7e4);
    check_val(24'(driver_format_field), 24'h0000e4);
    check_val(24'({crystal_amp_gain, crystal_load_cap}), 24'h3f);
    check_val(24'(crystal_freq_trim), 24'h000001);
    host.wr(REG2_ADDR, 24'h03ff0f);
    wait_for(1'b0, 1'b1, n);
    wait_for(1'b1, 1'b1, n);
    check_cnt(n, SETTLE);
    check_val(24'(comp_pin_oe), 24'h00001e);
    check_val(24'(true_pin_oe), 24'h00001f);
    host.wr(REG2_ADDR, 24'h01550f);
    wait_for(1'b1, 1'b0, n);
    check_val(24'(driver_bias_on), 24'h00001f);
    wait_for(1'b0, 1'b0, n);
    check_cnt(n, STOP);
    check_val(24'(true_pin_oe | comp_pin_oe), 24'h0);
    host.wr(REG2_ADDR, 24'h03ff0f);
    host.wr(REG2_ADDR, 24'h01550f);
    n = 0;
    repeat (12) begin
      @(posedge ref_clk);
      #1;
      if (clock_toggle_en !== 5'h00) n++;
    end
    check_cnt(n, 0);
    check_val(24'(driver_bias_on), 24'h0);
    $display("test sequence done");
    output_enable_pin = 4'h0;
    reference_buffer_enable_pin = 1'b0;
    first_synth_powerdown_pin_n = 1'b0;
    otp_output_ctrl = 24'h000d0f;
    otp_load = 1'b1;
    @(posedge ref_clk);
    #1;
    otp_load = 1'b0;
    otp_output_ctrl = 24'hfff2f0;
    repeat (16) @(posedge ref_clk);
    #1;
    check_val(24'(driver_bias_on), 24'h000002);
    host.wr(REG2_ADDR, 24'h03ff0f);
    repeat (16) @(posedge ref_clk);
    #1;
    check_val(24'(driver_bias_on), 24'h00001e);
    rstn = 1'b0;
    #1;
    check_val(24'({driver_bias_on, clock_toggle_en}), 24'h0);
    $display("test otp done");
    repeat (5) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    host.boot_wait(3);
    host.wr(REG2_ADDR, 24'h03ff0f);
    repeat (16) @(posedge ref_clk);
    #1;
    check_val(24'(driver_bias_on), 24'h00001f);
    $display("test restart done");
    give_verdict();
  end
endmodule
